// ===== design/pll_hold_cal_pkg.sv
// Purpose: constants shared by the holdover / calibration control block
// Assumes: 8-bit registers on a 10-bit address port
// Notes:   offsets are byte addresses of the register map
package pll_hold_cal_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [9:0] OFF_LD_CAL   = 10'h018;
  localparam logic [9:0] OFF_LDPIN    = 10'h01a;
  localparam logic [9:0] OFF_REFERENCE_MONITOR_PIN   = 10'h01b;
  localparam logic [9:0] OFF_REFCTL   = 10'h01c;
  localparam logic [9:0] OFF_HOLD     = 10'h01d;
  localparam logic [9:0] OFF_STATUS   = 10'h01f;
  localparam logic [9:0] OFF_UPDATE   = 10'h232;
  // reset values
  localparam logic [7:0] RST_LD_CAL   = 8'h00;
  localparam logic [7:0] RST_LDPIN    = 8'h00;
  localparam logic [7:0] RST_REFERENCE_MONITOR_PIN   = 8'h00;
  localparam logic [7:0] RST_REFCTL   = 8'h00;
  localparam logic [7:0] RST_HOLD     = 8'h00;
  // field positions, lock detect / calibration register
  localparam int B_CAL_START  = 0;
  localparam int B_CALDIV_LO  = 1;
  localparam int B_DLD_OFF    = 3;
  localparam int B_LDWIN      = 4;
  localparam int B_LDCNT_LO   = 5;
  // holdover register
  localparam int B_HOLD_EN0   = 0;
  localparam int B_EXT_HOLD   = 1;
  localparam int B_HOLD_EN2   = 2;
  localparam int B_LDCMP_EN   = 3;
  // reference control and monitor config
  localparam int B_REF_SEL    = 0;
  localparam int B_MON_EXT    = 6;
  // status readback and update strobe bit
  localparam int B_ST_REF1LO  = 1;
  localparam int B_ST_REF2LO  = 2;
  localparam int B_ST_VCOLO   = 3;
  localparam int B_ST_CALDONE = 6;
  localparam int B_UPDATE     = 0;
  // calibration length in calibration clock cycles
  localparam int CAL_CYCLES   = 4400;
  // lock detect counter codes: 5, 16, 64, 255 cycles
  localparam logic [7:0] LDCNT_0 = 8'h05;
  localparam logic [7:0] LDCNT_1 = 8'h10;
  localparam logic [7:0] LDCNT_2 = 8'h40;
  localparam logic [7:0] LDCNT_3 = 8'hff;
  // calibration divider codes: 2, 4, 8, 16
  localparam logic [4:0] CALDIV_0 = 5'h02;
  localparam logic [4:0] CALDIV_1 = 5'h04;
  localparam logic [4:0] CALDIV_2 = 5'h08;
  localparam logic [4:0] CALDIV_3 = 5'h10;
  typedef enum logic [2:0] {
    HOLD_IDLE  = 3'b001,
    HOLD_ACT   = 3'b010,
    HOLD_REARM = 3'b100
  } hold_state_t;
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN  = 3'b010,
    CAL_DONE = 3'b100
  } cal_state_t;
endpackage : pll_hold_cal_pkg

// ===== design/pll_holdover_vco_cal_ctrl.sv
// Purpose: holdover controller, frequency monitor status, oscillator calibration sequencer
// Assumes: phase detector events, lock flag and monitor flags come as core-clock pulses/levels;
//          the lock indicator pin is asynchronous and is synchronised here
// Notes:   calibration counts divided phase detector events, so it ends only with a live reference
//
// Functional notes
// - automatic holdover tri-states charge pump when lock is lost
// - holdover entry uses lock indicator pin level, whatever mode drives it
// - comparator disabled means the pin is seen as always high
// - charge pump stays high impedance while no reference is present
// - leaving holdover on reference event resets B counter, never the prescaler
// - auto mode: no re-entry until relock and pin charged again; external mode has no such wait
// - holdover follows selected reference; switchover loss ends at next reference edge
// - lock detect counter field sets in-window cycles; code 00b means five
// - both enable bits needed; otherwise no holdover of any kind
// - external-control bit: zero automatic, one external pin
// - lock window bit cleared selects the high range window
// - three frequency monitors reported in status bits 3 to 1
// - calibration runs off R divider events and needs a reference
// - calibrate bit starts calibration even before first update
// - calibration-finished bit reads one once calibration completes
// - internal sync held during calibration, released at its end
// - calibration clock is detector rate over divider; lasts 4400 cycles
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
module pll_holdover_vco_cal_ctrl #(
  parameter int CAL_LEN = pll_hold_cal_pkg::CAL_CYCLES
) (
  input  wire logic                                 CORE_CLK,
  input  wire logic                                 RST_N,
  input  wire logic [pll_hold_cal_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [pll_hold_cal_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                                 WR,
  input  wire logic                                 RD,
  output logic      [pll_hold_cal_pkg::DATA_W-1:0]  RDATA,
  input  wire logic                                 LOCK_INDICATOR_PIN,
  input  wire logic                                 EXT_HOLD_PIN_N,
  input  wire logic                                 DIGITAL_LOCK_FLAG,
  input  wire logic                                 IN_WINDOW,
  input  wire logic                                 REF_PFD_EVENT,
  input  wire logic                                 FIRST_REF_PRESENT,
  input  wire logic                                 SECOND_REF_PRESENT,
  input  wire logic                                 FIRST_REF_LOW,
  input  wire logic                                 SECOND_REF_LOW,
  input  wire logic                                 VCO_LOW,
  output logic                                      CHARGE_PUMP_HIZ,
  output logic                                      B_COUNTER_RESET,
  output logic                                      INTERNAL_SYNC,
  output logic                                      CAL_ACTIVE,
  output logic                                      LOCK_COUNT_OK,
  output logic                                      LD_WINDOW_HIGH,
  output logic                                      DLD_DISABLE,
  output logic                                      MON_EXTENDED,
  output logic                                      REF_SELECT
);
  import pll_hold_cal_pkg::*;

  // operating overview for the next engineer
  // register bus
  //   writes land on the edge that sees the write strobe
  //   read data is registered and shows only in the cycle after the read
  //   the update register holds no state; a write to it is a strobe
  //   the status register is read only; writes to it are dropped
  //   unmapped addresses read as zero and ignore writes
  // lock pin path
  //   the pin is asynchronous, so two flops sit in front of any logic
  //   the synchroniser resets low, so an enabled comparator sees a low pin
  //   for two cycles after reset; holdover is off at reset, so no false entry
  //   with the comparator disabled the pin is read as high and auto entry
  //   can never happen; this is intended, not a fault
  // external hold pin
  //   entry is on a synchronised falling edge only, never on a level
  //   its edge flop resets high, the idle level of the pin, so no false edge
  //   exit also needs the pin high again, checked on the same detector event
  // holdover state machine
  //   idle   : charge pump drives normally
  //   act    : charge pump tri-stated, waiting for a detector event
  //   rearm  : auto mode only; waits for lock flag and charged pin together
  //   dropping either enable bit forces idle at once, whatever the state
  //   only events of the selected reference may end holdover, so a
  //   live but unselected other reference does not cut it short
  //   with no reference present no event comes and the pump stays tri-stated
  // B counter reset
  //   a one-cycle pulse in the cycle after the exit event
  //   the prescaler is never touched here; that stays outside this block
  //   it shares its exit term with the state machine so both agree exactly
  // lock detect counter
  //   counts consecutive in-window detector events up to the chosen need
  //   one out-of-window event clears the run
  //   the count saturates so a long lock does not wrap back to zero
  //   lowering the need below a held count lets in-window events carry the count on past it;
  //   it then reads not ok until it wraps through zero up to the need, or an out-of-window event clears it
  // calibration start
  //   the calibrate bit is compared with a stored copy of itself
  //   the copy resets low, so the first set after reset starts at once
  //   afterwards the copy only follows the bit on an update strobe,
  //   which gives the clear, update, set, update sequence its meaning
  //   a start while a calibration runs is held and begins once that run ends
  // calibration timing
  //   detector events are divided by 2, 4, 8 or 16 into calibration ticks
  //   the sequencer ends after the parameter count of ticks
  //   without a reference no events come and calibration never ends;
  //   software must make sure a reference is present first
  //   changing the divider code mid-run changes the remaining time only
  // sync and status
  //   the internal sync is high exactly while the sequencer runs
  //   the finished bit stays set until the next calibration starts
  //   the loop may still be settling when sync is released
  // software duties not enforced here
  //   keep digital lock detect enabled while auto holdover is in use
  //   select the current-source lock mode before enabling the comparator
  //   enable holdover only after calibration, and disable it before one

  // elaboration check: the sequencer counter is sixteen bits wide
  if (CAL_LEN < 1 || CAL_LEN > 65535) begin : g_bad_cal_len
    $error("CAL_LEN out of range");
  end

  logic [7:0]  reg_ld_cal;
  logic [7:0]  reg_ldpin;
  logic [7:0]  reg_reference_monitor_pin;
  logic [7:0]  reg_refctl;
  logic [7:0]  reg_hold;
  logic        cal_done;
  logic        ld_meta;
  logic        ld_sync;
  logic        ext_meta;
  logic        ext_sync;
  logic        ext_prev;
  logic [7:0]  lock_run;
  logic [7:0]  lock_need;
  logic        ref_live;
  logic        ld_level;
  logic        hold_on;
  logic        auto_mode;
  hold_state_t hold_state;
  logic        cal_bit_prev;
  logic        cal_start;
  cal_state_t  cal_state;
  logic [4:0]  div_cnt;
  logic [4:0]  div_need;
  logic [15:0] cal_cnt;
  logic        cal_tick;
  logic [7:0]  status;

  // register writes; update register is a self-clearing strobe
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      reg_ld_cal <= RST_LD_CAL;
      reg_ldpin  <= RST_LDPIN;
      reg_reference_monitor_pin <= RST_REFERENCE_MONITOR_PIN;
      reg_refctl <= RST_REFCTL;
      reg_hold   <= RST_HOLD;
    end else if (WR) begin
      if (ADDR == OFF_LD_CAL) begin
        reg_ld_cal <= WDATA;
      end else if (ADDR == OFF_LDPIN) begin
        reg_ldpin <= WDATA;
      end else if (ADDR == OFF_REFERENCE_MONITOR_PIN) begin
        reg_reference_monitor_pin <= WDATA;
      end else if (ADDR == OFF_REFCTL) begin
        reg_refctl <= WDATA;
      end else if (ADDR == OFF_HOLD) begin
        reg_hold <= WDATA;
      end
    end
  end

  // status byte: calibration finished and monitor flags
  always_comb begin
    status = 8'h00;
    status[B_ST_REF1LO]  = FIRST_REF_LOW;
    status[B_ST_REF2LO]  = SECOND_REF_LOW;
    status[B_ST_VCOLO]   = VCO_LOW;
    status[B_ST_CALDONE] = cal_done;
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      if (ADDR == OFF_LD_CAL) begin
        RDATA <= reg_ld_cal;
      end else if (ADDR == OFF_LDPIN) begin
        RDATA <= reg_ldpin;
      end else if (ADDR == OFF_REFERENCE_MONITOR_PIN) begin
        RDATA <= reg_reference_monitor_pin;
      end else if (ADDR == OFF_REFCTL) begin
        RDATA <= reg_refctl;
      end else if (ADDR == OFF_HOLD) begin
        RDATA <= reg_hold;
      end else if (ADDR == OFF_STATUS) begin
        RDATA <= status;
      end else begin
        RDATA <= 8'h00;
      end
    end else begin
      RDATA <= 8'h00;
    end
  end

  // two-stage synchronisers for the pins
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ld_meta  <= 1'b0;
      ld_sync  <= 1'b0;
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
      ext_prev <= 1'b1;
    end else begin
      ld_meta  <= LOCK_INDICATOR_PIN;
      ld_sync  <= ld_meta;
      ext_meta <= EXT_HOLD_PIN_N;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // lock detect counter threshold
  always_comb begin
    case (reg_ld_cal[B_LDCNT_LO +: 2])
      2'b00:   lock_need = LDCNT_0;
      2'b01:   lock_need = LDCNT_1;
      2'b10:   lock_need = LDCNT_2;
      default: lock_need = LDCNT_3;
    endcase
  end

  // count consecutive in-window detector cycles
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_run <= 8'h00;
    end else if (REF_PFD_EVENT) begin
      if (!IN_WINDOW) begin
        lock_run <= 8'h00;
      end else if (lock_run != lock_need) begin
        lock_run <= lock_run + 8'h01;
      end
    end
  end

  assign LOCK_COUNT_OK  = (lock_run == lock_need);
  assign LD_WINDOW_HIGH = ~reg_ld_cal[B_LDWIN];
  assign DLD_DISABLE    = reg_ld_cal[B_DLD_OFF];
  assign MON_EXTENDED   = reg_ldpin[B_MON_EXT];
  assign REF_SELECT     = reg_refctl[B_REF_SEL];
  // holdover follows the selected reference only
  assign ref_live  = REF_SELECT ? SECOND_REF_PRESENT : FIRST_REF_PRESENT;
  // disabled comparator reads the pin as high
  assign ld_level  = reg_hold[B_LDCMP_EN] ? ld_sync : 1'b1;
  assign hold_on   = reg_hold[B_HOLD_EN0] & reg_hold[B_HOLD_EN2];
  assign auto_mode = hold_on & ~reg_hold[B_EXT_HOLD];

  // holdover state machine
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_state <= HOLD_IDLE;
    end else if (!hold_on) begin
      hold_state <= HOLD_IDLE;
    end else begin
      case (hold_state)
        HOLD_IDLE: begin
          if (auto_mode && !ld_level) begin
            hold_state <= HOLD_ACT;
          end else if (!auto_mode && ext_prev && !ext_sync) begin
            hold_state <= HOLD_ACT;
          end
        end
        HOLD_ACT: begin
          // exit only on a reference edge, so no reference keeps it high impedance
          if (REF_PFD_EVENT && ref_live && (auto_mode || ext_sync)) begin
            hold_state <= auto_mode ? HOLD_REARM : HOLD_IDLE;
          end
        end
        HOLD_REARM: begin
          if (DIGITAL_LOCK_FLAG && ld_level) begin
            hold_state <= HOLD_IDLE;
          end
        end
        default: hold_state <= HOLD_IDLE;
      endcase
    end
  end

  assign CHARGE_PUMP_HIZ = (hold_state == HOLD_ACT);

  // B counter reset pulse when leaving holdover on a reference event
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      B_COUNTER_RESET <= 1'b0;
    end else begin
      B_COUNTER_RESET <= hold_on && (hold_state == HOLD_ACT) && REF_PFD_EVENT && ref_live &&
                         (auto_mode || ext_sync);
    end
  end

  // calibrate bit rising edge; prev resets low so a first set starts at once
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cal_bit_prev <= 1'b0;
    end else if (WR && ADDR == OFF_UPDATE && WDATA[B_UPDATE]) begin
      cal_bit_prev <= reg_ld_cal[B_CAL_START];
    end else if (cal_start) begin
      cal_bit_prev <= 1'b1;
    end
  end

  assign cal_start = reg_ld_cal[B_CAL_START] && !cal_bit_prev && (cal_state != CAL_RUN);

  // calibration divider select
  always_comb begin
    case (reg_ld_cal[B_CALDIV_LO +: 2])
      2'b00:   div_need = CALDIV_0;
      2'b01:   div_need = CALDIV_1;
      2'b10:   div_need = CALDIV_2;
      default: div_need = CALDIV_3;
    endcase
  end

  assign cal_tick = REF_PFD_EVENT && (div_cnt == div_need - 5'h01);

  // divide detector events down to calibration clock
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt <= 5'h00;
    end else if (cal_state != CAL_RUN) begin
      div_cnt <= 5'h00;
    end else if (REF_PFD_EVENT) begin
      div_cnt <= cal_tick ? 5'h00 : div_cnt + 5'h01;
    end
  end

  // calibration sequencer
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cal_state <= CAL_IDLE;
      cal_cnt   <= 16'h0000;
    end else begin
      case (cal_state)
        CAL_IDLE, CAL_DONE: begin
          if (cal_start) begin
            cal_state <= CAL_RUN;
            cal_cnt   <= 16'h0000;
          end
        end
        CAL_RUN: begin
          if (cal_tick) begin
            if (cal_cnt == 16'(CAL_LEN - 1)) begin
              cal_state <= CAL_DONE;
            end else begin
              cal_cnt <= cal_cnt + 16'h0001;
            end
          end
        end
        default: cal_state <= CAL_IDLE;
      endcase
    end
  end

  assign cal_done      = (cal_state == CAL_DONE);
  assign CAL_ACTIVE    = (cal_state == CAL_RUN);
  assign INTERNAL_SYNC = (cal_state == CAL_RUN);
endmodule // pll_holdover_vco_cal_ctrl

// ===== dv/pll_far_side_model.sv
// Purpose: far side: detector events, lock flag, lock pin
// Assumes: an event every 4 core cycles, or 8 when slow
// Notes:   lock pin charges like a capacitor on a current source
`timescale 1ns/10ps
module pll_far_side_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ref_on,
  input  wire logic lock_on,
  input  wire logic slow,
  output logic      ref_event,
  output logic      ref_present,
  output logic      lock_pin,
  output logic      dlock,
  output logic      in_window
);
  logic [3:0] phase;
  logic [3:0] charge;
  // divided reference rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      phase <= 4'h0;
    else
      phase <= (phase >= (slow ? 4'h7 : 4'h3)) ? 4'h0 : phase + 4'h1;
  end
  // pin charges while locked, drops at once on any loss
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      charge <= 4'h0;
    else if (!lock_on)
      charge <= 4'h0;
    else if (charge != 4'h8)
      charge <= charge + 4'h1;
  end
  // events only with a live reference
  assign ref_event   = ref_on && (phase == 4'h0);
  assign ref_present = ref_on;
  assign dlock       = lock_on;
  assign in_window   = lock_on;
  assign lock_pin    = (charge == 4'h8);
endmodule // pll_far_side_model

// ===== dv/pll_hold_cal_monitor.sv
// Purpose: port checks for the holdover and calibration block
// Assumes: CAL_LEN matches the bound instance
// Notes:   bound below to every instance
`timescale 1ns/10ps
module pll_hold_cal_monitor
  import pll_hold_cal_pkg::*;
#(
  parameter int CAL_LEN = 4
) (
  input wire logic                                CORE_CLK,
  input wire logic                                RST_N,
  input wire logic [pll_hold_cal_pkg::ADDR_W-1:0] ADDR,
  input wire logic [pll_hold_cal_pkg::DATA_W-1:0] WDATA,
  input wire logic                                WR,
  input wire logic                                RD,
  input wire logic [pll_hold_cal_pkg::DATA_W-1:0] RDATA,
  input wire logic                                REF_PFD_EVENT,
  input wire logic                                FIRST_REF_LOW,
  input wire logic                                SECOND_REF_LOW,
  input wire logic                                VCO_LOW,
  input wire logic                                CHARGE_PUMP_HIZ,
  input wire logic                                B_COUNTER_RESET,
  input wire logic                                INTERNAL_SYNC,
  input wire logic                                CAL_ACTIVE,
  input wire logic                                LD_WINDOW_HIGH,
  input wire logic                                DLD_DISABLE,
  input wire logic                                REF_SELECT
);
  localparam int EV_MIN = 2 * CAL_LEN;
  localparam int EV_MAX = 16 * CAL_LEN;
  logic [15:0] ev_cnt;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // detector events seen while calibrating
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N)
      ev_cnt <= 16'h0000;
    else if (!INTERNAL_SYNC)
      ev_cnt <= 16'h0000;
    else if (REF_PFD_EVENT)
      ev_cnt <= ev_cnt + 16'h0001;
  end
  AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside read slot");
  AST_ST_READ: assert property ($past(RD) && $past(ADDR) == OFF_STATUS |->
    RDATA[3:1] == $past({VCO_LOW, SECOND_REF_LOW, FIRST_REF_LOW})) else $error("monitor status wrong");
  AST_CAL_RD: assert property ($past(RD) && $past(ADDR) == OFF_STATUS && $past(CAL_ACTIVE) |-> !RDATA[6])
    else $error("finished bit set while calibrating");
  AST_CAL_START: assert property ($rose(INTERNAL_SYNC) |-> $past(WR, 2) && $past(WDATA[0], 2) &&
    ($past(ADDR, 2) == OFF_LD_CAL || $past(ADDR, 2) == OFF_UPDATE)) else $error("sync rose without start");
  AST_CAL_LEN: assert property ($fell(INTERNAL_SYNC) |-> ev_cnt inside {[EV_MIN - 1:EV_MAX + 1]})
    else $error("calibration length wrong");
  AST_HIZ_STAY: assert property (CHARGE_PUMP_HIZ && !REF_PFD_EVENT && !WR |=> CHARGE_PUMP_HIZ)
    else $error("charge pump left tri-state without event");
  AST_BRST_CAUSE: assert property (B_COUNTER_RESET |-> $fell(CHARGE_PUMP_HIZ) && $past(REF_PFD_EVENT))
    else $error("counter reset without holdover exit");
  AST_HIZ_EXIT: assert property ($fell(CHARGE_PUMP_HIZ) && !$past(WR) |-> B_COUNTER_RESET ##1 !B_COUNTER_RESET)
    else $error("exit without one-cycle counter reset");
  AST_CFG_OUT: assert property ($past(WR) && $past(ADDR) == OFF_LD_CAL |->
    LD_WINDOW_HIGH == !$past(WDATA[4]) && DLD_DISABLE == $past(WDATA[3])) else $error("window outputs wrong");
  AST_REF_SEL: assert property ($past(WR) && $past(ADDR) == OFF_REFCTL |-> REF_SELECT == $past(WDATA[0]))
    else $error("reference select wrong");
  COV_HOLD: cover property ($rose(CHARGE_PUMP_HIZ));
  COV_EXIT: cover property (B_COUNTER_RESET);
  COV_CAL: cover property ($fell(INTERNAL_SYNC));
endmodule // pll_hold_cal_monitor
bind pll_holdover_vco_cal_ctrl pll_hold_cal_monitor #(.CAL_LEN(CAL_LEN)) mon_inst (.*);

// ===== dv/testbench.sv
// Purpose: self-checking bench for the holdover and calibration block
// Assumes: far side model feeds events and lock pin
// Notes:   short calibration length keeps the run brief
`timescale 1ns/10ps
module testbench;
  import pll_hold_cal_pkg::*;
  localparam int CLEN = 4;
  logic              CORE_CLK, RST_N, WR, RD, EXT_HOLD_PIN_N, ref_on, lock_on, slow;
  logic              FIRST_REF_LOW, SECOND_REF_LOW, VCO_LOW, FIRST_REF_PRESENT, SECOND_REF_PRESENT;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA, RDATA;
  logic              LOCK_INDICATOR_PIN, DIGITAL_LOCK_FLAG, IN_WINDOW, REF_PFD_EVENT, CHARGE_PUMP_HIZ;
  logic              B_COUNTER_RESET, INTERNAL_SYNC, CAL_ACTIVE, LOCK_COUNT_OK, LD_WINDOW_HIGH;
  logic              DLD_DISABLE, MON_EXTENDED, REF_SELECT;
  logic [9:0]        regs [5] = '{OFF_LD_CAL, OFF_LDPIN, OFF_REFERENCE_MONITOR_PIN, OFF_REFCTL, OFF_HOLD};
  logic [7:0]        cfg [3] = '{8'h05, 8'h09, 8'h0c};
  int                err_count, checks_done, cycles, n;
  pll_holdover_vco_cal_ctrl #(.CAL_LEN(CLEN)) pll_holdover_vco_cal_ctrl_inst (.*);
  pll_far_side_model pll_far_side_model_inst (.clk(CORE_CLK), .rst_n(RST_N), .ref_on(ref_on),
    .lock_on(lock_on), .slow(slow), .ref_event(REF_PFD_EVENT), .ref_present(FIRST_REF_PRESENT),
    .lock_pin(LOCK_INDICATOR_PIN), .dlock(DIGITAL_LOCK_FLAG), .in_window(IN_WINDOW));
  assign SECOND_REF_PRESENT = FIRST_REF_PRESENT;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1 chk(RDATA, e);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge CORE_CLK);
    #1;
  endtask
  // bounded wait for the charge pump state
  task automatic hiz(input logic v, input int lim);
    for (int i = 0; i < lim && CHARGE_PUMP_HIZ !== v; i++) tick(1);
    chk(CHARGE_PUMP_HIZ, v);
  endtask
  task automatic finish_test();
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  // stall guard
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      $display("BAD %0t run stalled", $time);
      finish_test();
    end
  end
  initial begin
    {RST_N, WR, RD, FIRST_REF_LOW, SECOND_REF_LOW, VCO_LOW, ref_on, lock_on, slow, ADDR, WDATA} = '0;
    EXT_HOLD_PIN_N = 1'b1;
    repeat (20) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    wr(OFF_STATUS, 8'hff);
    wr(10'h3ff, 8'hff);
    rd(10'h3ff, 8'h00);
    rd(OFF_UPDATE, 8'h00);
    foreach (regs[i]) wr(regs[i], 8'he4);
    foreach (regs[i]) rd(regs[i], 8'he4);
    chk({LD_WINDOW_HIGH, DLD_DISABLE, MON_EXTENDED, REF_SELECT}, 8'h0a);
    wr(OFF_REFCTL, 8'h01);
    #1 chk(REF_SELECT, 8'h01);
    wr(OFF_HOLD, 8'h00);
    for (int i = 0; i < 3; i++) begin
      @(posedge CORE_CLK);
      {VCO_LOW, SECOND_REF_LOW, FIRST_REF_LOW} <= 3'(1 << i);
      tick(3);
      rd(OFF_STATUS, 8'(2 << i));
    end
    @(posedge CORE_CLK);
    {VCO_LOW, ref_on} <= 2'b01;
    wr(OFF_LD_CAL, 8'h00);
    tick(12);
    @(posedge CORE_CLK);
    lock_on <= 1'b1;
    #1 n = 0;
    for (int i = 0; i < 60 && LOCK_COUNT_OK !== 1'b1; i++) begin
      n += REF_PFD_EVENT;
      tick(1);
    end
    chk(8'(n), 8'h05);
    wr(OFF_LD_CAL, 8'h01);
    tick(1);
    chk({INTERNAL_SYNC, CAL_ACTIVE}, 8'h03);
    n = 0;
    for (int i = 0; i < 400 && INTERNAL_SYNC === 1'b1; i++) begin
      n += REF_PFD_EVENT;
      tick(1);
    end
    chk(8'(n), 8'(2 * CLEN));
    rd(OFF_STATUS, 8'h40);
    @(posedge CORE_CLK);
    slow <= 1'b1;
    wr(OFF_LD_CAL, 8'h00);
    wr(OFF_UPDATE, 8'h01);
    wr(OFF_LD_CAL, 8'h01);
    wr(OFF_UPDATE, 8'h01);
    rd(OFF_STATUS, 8'h00);
    for (int i = 0; i < 900 && INTERNAL_SYNC === 1'b1; i++) tick(1);
    rd(OFF_STATUS, 8'h40);
    @(posedge CORE_CLK);
    slow <= 1'b0;
    wr(OFF_LDPIN, 8'h04);
    wr(OFF_HOLD, 8'h0d);
    tick(6);
    chk(CHARGE_PUMP_HIZ, 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge CORE_CLK);
      {ref_on, lock_on} <= 2'b00;
      hiz(1'b1, 8);
      tick(30);
      chk(CHARGE_PUMP_HIZ, 8'h01);
      @(posedge CORE_CLK);
      ref_on <= 1'b1;
      hiz(1'b0, 8);
      chk(B_COUNTER_RESET, 8'h01);
      tick(20);
      chk(CHARGE_PUMP_HIZ, 8'h00);
      @(posedge CORE_CLK);
      lock_on <= 1'b1;
      tick(20);
    end
    foreach (cfg[i]) begin
      wr(OFF_HOLD, cfg[i]);
      @(posedge CORE_CLK);
      lock_on <= 1'b0;
      tick(12);
      chk(CHARGE_PUMP_HIZ, 8'h00);
      @(posedge CORE_CLK);
      lock_on <= 1'b1;
      tick(14);
    end
    wr(OFF_HOLD, 8'h07);
    @(posedge CORE_CLK);
    {ref_on, EXT_HOLD_PIN_N} <= 2'b00;
    hiz(1'b1, 6);
    @(posedge CORE_CLK);
    EXT_HOLD_PIN_N <= 1'b1;
    tick(12);
    chk(CHARGE_PUMP_HIZ, 8'h01);
    @(posedge CORE_CLK);
    ref_on <= 1'b1;
    hiz(1'b0, 10);
    finish_test();
  end
endmodule // testbench
